// File: rtl/itc_timing_core.sv
// inverse-time overcurrent stage timers and thermal overload state
// assumes one clock, synchronous reset, current magnitudes already rms
// Functional notes
// - inverse delay is tms times k over (ratio to the alpha minus p) plus c.
// - iec standard, very, extremely and long time inverse use their k and alpha.
// - short time inverse and rectifier curves use their own k and alpha.
// - us and ieee curves use their own k, c pairs with alpha 0.02 or 2.
// - ri curve uses negative k and alpha, only for ratios 1.1 to 20.
// - log earth time is 5.8 minus 1.35 ln of 1/(k pickup/measured).
// - log earth curve only on first earth stage with medium sensitivity.
// - running delay resets only after current stays below 95% for reset time.
// - a trip clears the stage delay immediately, no reset hold.
// - definite reset time 0 to 600 ms on phase 1, 2 and earth 1.
// - inverse reset on non-inverse-reset curves forces zero reset time.
// - inverse reset is multiplier times tr over (1 minus ratio to the p).
// - iec standard, very and extremely inverse use their own tr and p reset constants; long time inverse is forced to zero.
// - us and ieee curves reset with p 2 and own tr, others tr 0.
// - earth stages 2 and 3 only have a definite reset time.
// - thermal state updated every 10 ms with the exponential heating law.
// - equivalent thermal current is the highest phase current.
// - above 0.1 thermal setting, thermal trip time is te ln of state ratio.
// - thermal states are held as fractions, 1 meaning 100%.
// - cooling constant replaces heating constant under the phase condition.
// - with cut chosen, above 20 times pickup the 20 times delay is used.
`timescale 1ns/1ps
module itc_timing_core
  import itc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire itc_meas_s meas,
  input wire itc_stage_cfg_s [NSTAGE-1:0] stage_cfg,
  input wire itc_therm_cfg_s therm_cfg,
  input wire logic med_sens,
  input wire logic cut_en,
  output logic [NSTAGE-1:0] stage_start,
  output logic [NSTAGE-1:0] stage_trip,
  output logic [MSW-1:0] thermal_trip_ms,
  output itc_fx_t thermal_state,
  output logic thermal_trip
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [31:0] tick_cnt;
    logic tick;
    logic [NSTAGE-1:0][MSW-1:0] elapsed;
    logic [NSTAGE-1:0][MSW-1:0] below;
    logic [NSTAGE-1:0] start;
    logic [NSTAGE-1:0] trip;
    itc_fx_t theta;
    logic th_loaded;
    logic th_trip;
    logic [MSW-1:0] th_ms;
  } itc_core_state_s;

  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
  localparam logic [MSW-1:0] TICK_W = MSW'(TICK_MS);

  itc_core_state_s q_r, q_nxt;

  // ==========================================================
  // per-stage curve evaluation
  logic [CW-1:0] ieq;
  logic [NSTAGE-1:0][CW-1:0] s_meas;
  logic [NSTAGE-1:0][MSW-1:0] op_ms;
  logic [NSTAGE-1:0][MSW-1:0] rst_ms;
  logic [NSTAGE-1:0] pick, drop;

  always_comb begin
    ieq = meas.phase[0];
    for (int i = 1; i < 3; i++) begin
      if (meas.phase[i] > ieq) ieq = meas.phase[i];
    end
  end

  for (genvar s = 0; s < NSTAGE; s++) begin : g_stage
    assign s_meas[s] = (s < STG_EARTH1) ? ieq : meas.earth;
    assign pick[s] = s_meas[s] > stage_cfg[s].pickup_threshold;
    assign drop[s] = fx_int(longint'(s_meas[s])) <
                     fx_mul(DROP_FR, fx_int(longint'(stage_cfg[s].pickup_threshold)));

    itc_curve u_curve (
      .cfg(stage_cfg[s]),
      .meas(s_meas[s]),
      .log_ok((s == STG_EARTH1) && med_sens),
      .inv_ok(s < STG_EARTH2),
      .cut_en(cut_en),
      .op_ms(op_ms[s]),
      .rst_ms(rst_ms[s])
    );
  end

  // ==========================================================
  // thermal arithmetic
  itc_fx_t ith_fx, kk, k2, tau, decay, th_new, lo_lvl;
  logic any_hi, all_hi;

  assign ith_fx = fx_int(longint'(therm_cfg.thermal_current_setting));
  assign lo_lvl = fx_mul(TH_LOW, ith_fx);
  always_comb begin
    any_hi = 1'b0;
    all_hi = 1'b1;
    for (int i = 0; i < 3; i++) begin
      if (fx_int(longint'(meas.phase[i])) > lo_lvl) any_hi = 1'b1;
      else all_hi = 1'b0;
    end
  end
  assign kk = fx_div(fx_int(longint'(ieq)), fx_mul(TH_DEN, ith_fx));
  assign k2 = fx_mul(kk, kk);
  // cooling constant only when every phase sits above the low level
  assign tau = all_hi ? therm_cfg.cooling_time_constant
                      : therm_cfg.heating_time_constant;
  assign decay = fx_exp2(-fx_mul(fx_div(fx_div(fx_int(TICK_MS), fx_int(MS_PER_S)), tau),
                                 LOG2E));
  assign th_new = fx_mul(k2, FX_ONE - decay) + fx_mul(q_r.theta, decay);

  function automatic itc_fx_t fx_abs(input itc_fx_t v);
    return (v < 0) ? -v : v;
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    q_nxt = q_r;
    q_nxt.tick = 1'b0;
    if (q_r.tick_cnt >= TICK_LAST) begin
      q_nxt.tick_cnt = '0;
      q_nxt.tick = 1'b1;
    end else begin
      q_nxt.tick_cnt = q_r.tick_cnt + 32'h1;
    end
    if (q_r.tick) begin
      for (int s = 0; s < NSTAGE; s++) begin
        if (!stage_cfg[s].en) begin
          q_nxt.elapsed[s] = '0;
          q_nxt.below[s] = '0;
          q_nxt.start[s] = 1'b0;
          q_nxt.trip[s] = 1'b0;
        end else if (pick[s]) begin
          q_nxt.start[s] = 1'b1;
          q_nxt.below[s] = '0;
          if (q_r.elapsed[s] + TICK_W >= op_ms[s]) begin
            q_nxt.trip[s] = 1'b1;
            q_nxt.elapsed[s] = '0;
          end else begin
            q_nxt.elapsed[s] = q_r.elapsed[s] + TICK_W;
          end
        end else begin
          q_nxt.start[s] = 1'b0;
          if (drop[s]) begin
            q_nxt.trip[s] = 1'b0;
            if (q_r.elapsed[s] != '0) begin
              // hold the running delay until the reset time has expired
              if (q_r.below[s] + TICK_W >= rst_ms[s]) begin
                q_nxt.elapsed[s] = '0;
                q_nxt.below[s] = '0;
              end else begin
                q_nxt.below[s] = q_r.below[s] + TICK_W;
              end
            end
          end else begin
            q_nxt.below[s] = '0;
          end
        end
      end
      if (!q_r.th_loaded) begin
        q_nxt.theta = therm_cfg.init_state;
        q_nxt.th_loaded = 1'b1;
      end else begin
        q_nxt.theta = th_new;
      end
    end
    q_nxt.th_trip = q_r.th_loaded && (q_r.theta >= therm_cfg.trip_state);
    if (!any_hi || q_nxt.th_trip) begin
      q_nxt.th_ms = '0;
    end else begin
      q_nxt.th_ms = fx_ms(fx_mul(therm_cfg.heating_time_constant,
                                 fx_ln(fx_div(fx_abs(k2 - q_r.theta),
                                              fx_abs(k2 - therm_cfg.trip_state)))));
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign stage_start = q_r.start;
  assign stage_trip = q_r.trip;
  assign thermal_trip_ms = q_r.th_ms;
  assign thermal_state = q_r.theta;
  assign thermal_trip = q_r.th_trip;

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  for (genvar s = 0; s < NSTAGE; s++) begin : g_chk
    trip_clears_delay_a: assert property ($rose(q_r.trip[s]) |-> q_r.elapsed[s] == '0)
      else $error("stage delay not cleared on trip");
    trip_on_time_a: assert property (q_r.tick && stage_cfg[s].en && pick[s] &&
        q_r.elapsed[s] + TICK_W >= op_ms[s] |=> q_r.trip[s])
      else $error("stage did not trip at its delay");
    hold_keeps_delay_a: assert property (q_r.tick && stage_cfg[s].en && !pick[s] &&
        drop[s] && q_r.elapsed[s] != '0 && q_r.below[s] + TICK_W < rst_ms[s]
        |=> q_r.elapsed[s] == $past(q_r.elapsed[s]))
      else $error("delay reset before reset time");
    def_reset_cap_a: assert property (!stage_cfg[s].rst_inv |->
        rst_ms[s] <= MSW'(RST_MAX_MS))
      else $error("definite reset above limit");
    forced_zero_a: assert property (s < STG_EARTH2 && stage_cfg[s].rst_inv &&
        stage_cfg[s].curve == CRV_DMT |-> rst_ms[s] == '0)
      else $error("inverse reset not forced to zero");
    if (s >= STG_EARTH2) begin : g_earth
      earth_def_reset_a: assert property (rst_ms[s] <= MSW'(RST_MAX_MS))
        else $error("inverse reset on late earth stage");
    end
    if (s != STG_EARTH1) begin : g_nolog
      log_stage_only_a: assert property (stage_cfg[s].curve == CRV_LOG_EARTH |->
          op_ms[s] == stage_cfg[s].dmt_ms)
        else $error("log earth curve used on wrong stage");
    end
  end

  theta_on_tick_a: assert property (!q_r.tick |=> $stable(q_r.theta))
    else $error("thermal state moved between ticks");
  tick_spacing_a: assert property ($rose(q_r.tick) |=> !q_r.tick [*1])
    else $error("tick longer than one cycle");
  thermal_trip_a: assert property (q_r.th_loaded && q_r.theta >= therm_cfg.trip_state
      |=> q_r.th_trip)
    else $error("thermal trip missed");
  thermal_time_a: assert property (!any_hi |=> q_r.th_ms == '0)
    else $error("thermal time shown at low current");

endmodule

// File: rtl/itc_pkg.sv
// shared types, constants and fixed-point helpers for the inverse-time
// overcurrent and thermal timing engine; no clock or reset assumed here
package itc_pkg;

  // ==========================================================
  // sizes and timing
  localparam int FB = 16;
  localparam int FW = 48;
  localparam int CW = 16;
  localparam int MSW = 32;
  localparam int NSTAGE = 5;
  localparam int STG_EARTH1 = 2;
  localparam int STG_EARTH2 = 3;
  localparam int CLK_HZ = 40_000_000;
  localparam int MS_PER_S = 1000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYC = CLK_HZ / MS_PER_S * TICK_MS;
  localparam int RST_MAX_MS = 600;
  localparam real FX_ONE_R = 65536.0;

  typedef logic signed [FW-1:0] itc_fx_t;

  function automatic itc_fx_t fxr(input real r);
    return itc_fx_t'(longint'(r * FX_ONE_R));
  endfunction

  localparam itc_fx_t FX_ONE = fxr(1.0);
  localparam itc_fx_t FX_MAX = {2'b00, {(FW-2){1'b1}}};
  localparam itc_fx_t FX_MIN = {2'b11, {(FW-2){1'b0}}};
  localparam itc_fx_t DROP_FR = fxr(0.95);
  localparam itc_fx_t CUT_RATIO = fxr(20.0);
  localparam itc_fx_t RI_MIN = fxr(1.1);
  localparam itc_fx_t LOG_A = fxr(5.8);
  localparam itc_fx_t LOG_B = fxr(1.35);
  localparam itc_fx_t LOGK_MIN = fxr(0.3);
  localparam itc_fx_t RT_MIN = fxr(0.025);
  localparam itc_fx_t RT_MAX = fxr(1.5);
  localparam itc_fx_t LN2 = fxr(0.693147);
  localparam itc_fx_t LOG2E = fxr(1.442695);
  // quadratic term of the per-octave log2/exp2 fit
  localparam itc_fx_t LOG_CORR = fxr(0.34);
  localparam itc_fx_t TH_DEN = fxr(1.05);
  localparam itc_fx_t TH_LOW = fxr(0.1);

  // ==========================================================
  // curves and their constants
  typedef enum logic [3:0] {
    CRV_DMT, CRV_IEC_SI, CRV_IEC_VI, CRV_IEC_EI, CRV_IEC_LTI, CRV_FR_STI,
    CRV_US_P20, CRV_US_P40, CRV_US_LTI, CRV_IEEE_MI, CRV_IEEE_VI,
    CRV_IEEE_EI, CRV_RECT, CRV_UTIL, CRV_RI, CRV_LOG_EARTH
  } itc_curve_e;

  typedef struct packed {
    itc_fx_t k, c, al, p, tr, rp;
  } itc_par_s;

  localparam itc_par_s P_SI = '{fxr(0.14), '0, fxr(0.02), FX_ONE, fxr(8.2), fxr(6.45)};
  localparam itc_par_s P_VI = '{fxr(13.5), '0, FX_ONE, FX_ONE, fxr(50.92), fxr(2.4)};
  localparam itc_par_s P_EI = '{fxr(80.0), '0, fxr(2.0), FX_ONE, fxr(44.1), fxr(3.03)};
  localparam itc_par_s P_LTI = '{fxr(120.0), '0, FX_ONE, FX_ONE, fxr(40.62), fxr(0.4)};
  localparam itc_par_s P_STI = '{fxr(0.05), '0, fxr(0.04), FX_ONE, '0, fxr(2.0)};
  localparam itc_par_s P_P20 = '{fxr(0.02394), fxr(0.01694), fxr(0.02), FX_ONE,
                                 fxr(0.323), fxr(2.0)};
  localparam itc_par_s P_P40 = '{fxr(0.16758), fxr(0.11858), fxr(0.02), FX_ONE,
                                 fxr(2.261), fxr(2.0)};
  localparam itc_par_s P_ULT = '{fxr(5.95), fxr(0.18), fxr(2.0), FX_ONE, fxr(5.95), fxr(2.0)};
  localparam itc_par_s P_MI = '{fxr(0.0515), fxr(0.114), fxr(0.02), FX_ONE,
                                fxr(4.85), fxr(2.0)};
  localparam itc_par_s P_EVI = '{fxr(19.61), fxr(0.491), fxr(2.0), FX_ONE,
                                 fxr(21.6), fxr(2.0)};
  localparam itc_par_s P_EEI = '{fxr(28.2), fxr(0.1217), fxr(2.0), FX_ONE,
                                 fxr(29.1), fxr(2.0)};
  localparam itc_par_s P_RECT = '{fxr(45900.0), '0, fxr(5.6), FX_ONE, '0, fxr(2.0)};
  localparam itc_par_s P_UTIL = '{fxr(1000.0), fxr(0.655), fxr(2.0), FX_ONE, '0, fxr(2.0)};
  localparam itc_par_s P_RI = '{fxr(-4.2373), '0, -FX_ONE, fxr(1.43644), '0, fxr(2.0)};

  function automatic itc_par_s par_of(input itc_curve_e c);
    case (c)
      CRV_IEC_SI: return P_SI;
      CRV_IEC_VI: return P_VI;
      CRV_IEC_EI: return P_EI;
      CRV_IEC_LTI: return P_LTI;
      CRV_FR_STI: return P_STI;
      CRV_US_P20: return P_P20;
      CRV_US_P40: return P_P40;
      CRV_US_LTI: return P_ULT;
      CRV_IEEE_MI: return P_MI;
      CRV_IEEE_VI: return P_EVI;
      CRV_IEEE_EI: return P_EEI;
      CRV_RECT: return P_RECT;
      CRV_UTIL: return P_UTIL;
      CRV_RI: return P_RI;
      default: return '0;
    endcase
  endfunction

  // ==========================================================
  // carriers
  typedef struct packed {
    logic en;
    itc_curve_e curve;
    logic [CW-1:0] pickup_threshold;
    itc_fx_t tms;
    itc_fx_t reset_multiplier_iec;
    itc_fx_t reset_dial_us;
    itc_fx_t log_k;
    logic rst_inv;
    logic [MSW-1:0] dmt_ms;
    logic [MSW-1:0] rst_ms;
  } itc_stage_cfg_s;

  typedef struct packed {
    logic [CW-1:0] thermal_current_setting;
    itc_fx_t heating_time_constant;
    itc_fx_t cooling_time_constant;
    itc_fx_t trip_state;
    itc_fx_t init_state;
  } itc_therm_cfg_s;

  typedef struct packed {
    logic [2:0][CW-1:0] phase;
    logic [CW-1:0] earth;
  } itc_meas_s;

  // ==========================================================
  // fixed point, 16 fraction bits; log2/exp2 are quadratic per octave
  // a plain linear fit was up to a fifth off, too coarse for thermal decay
  function automatic itc_fx_t fx_int(input longint v);
    return itc_fx_t'(v) <<< FB;
  endfunction

  function automatic itc_fx_t fx_mul(input itc_fx_t a, input itc_fx_t b);
    logic signed [2*FW-1:0] m;
    m = a * b;
    return itc_fx_t'(m >>> FB);
  endfunction

  function automatic itc_fx_t fx_div(input itc_fx_t a, input itc_fx_t b);
    logic signed [2*FW-1:0] n;
    n = (2*FW)'(a) <<< FB;
    if (b == '0) return FX_MAX;
    return itc_fx_t'(n / (2*FW)'(b));
  endfunction

  function automatic itc_fx_t fx_log2(input itc_fx_t x);
    int msb;
    logic [FW-1:0] n;
    itc_fx_t f;
    msb = 0;
    if (x <= 0) return FX_MIN;
    for (int i = 0; i < FW; i++) if (x[i]) msb = i;
    n = FW'(x) << (FW - 1 - msb);
    f = itc_fx_t'(n[FW-2 -: FB]);
    return fx_int(longint'(msb - FB)) + f + fx_mul(LOG_CORR, fx_mul(f, FX_ONE - f));
  endfunction

  function automatic itc_fx_t fx_exp2(input itc_fx_t y);
    int e;
    itc_fx_t f, m;
    e = int'(y >>> FB);
    f = itc_fx_t'(y[FB-1:0]);
    m = FX_ONE + f - fx_mul(LOG_CORR, fx_mul(f, FX_ONE - f));
    if (e > FW - FB - 3) return FX_MAX;
    if (e < -FB) return '0;
    return (e >= 0) ? (m <<< e) : (m >>> (-e));
  endfunction

  function automatic itc_fx_t fx_pow(input itc_fx_t r, input itc_fx_t a);
    return fx_exp2(fx_mul(a, fx_log2(r)));
  endfunction

  function automatic itc_fx_t fx_ln(input itc_fx_t x);
    return fx_mul(fx_log2(x), LN2);
  endfunction

  function automatic logic [MSW-1:0] fx_ms(input itc_fx_t t);
    itc_fx_t m;
    m = fx_mul(t, fx_int(MS_PER_S)) >>> FB;
    if (t <= 0) return '0;
    if (m > itc_fx_t'({MSW{1'b1}})) return '1;
    return m[MSW-1:0];
  endfunction

endpackage

// File: rtl/itc_curve.sv
// operate and reset delays of one stage from its current and settings
// purely combinational; the caller samples the results on its tick
`timescale 1ns/1ps
module itc_curve
  import itc_pkg::*;
(
  input wire itc_stage_cfg_s cfg,
  input wire logic [CW-1:0] meas,
  input wire logic log_ok,
  input wire logic inv_ok,
  input wire logic cut_en,
  output logic [MSW-1:0] op_ms,
  output logic [MSW-1:0] rst_ms
);

  itc_par_s par;
  itc_fx_t r_raw, r, t, lk, rt;
  logic us_fam, forced;

  always_comb begin
    par = par_of(cfg.curve);
    r_raw = fx_div(fx_int(longint'(meas)), fx_int(longint'(cfg.pickup_threshold)));
    r = r_raw;
    if (cut_en && r > CUT_RATIO) r = CUT_RATIO;
    if (cfg.curve == CRV_RI) begin
      // outside this ratio band the ri expression is meaningless
      if (r < RI_MIN) r = RI_MIN;
      if (r > CUT_RATIO) r = CUT_RATIO;
    end
    lk = cfg.log_k;
    if (lk < LOGK_MIN) lk = LOGK_MIN;
    if (lk > FX_ONE) lk = FX_ONE;
    if (cfg.curve == CRV_LOG_EARTH) begin
      t = LOG_A - fx_mul(LOG_B, fx_ln(fx_div(FX_ONE, fx_mul(lk,
          fx_div(FX_ONE, r)))));
    end else begin
      t = fx_mul(cfg.tms, fx_div(par.k, fx_pow(r, par.al) - par.p) + par.c);
    end
    if (cfg.curve == CRV_DMT || (cfg.curve == CRV_LOG_EARTH && !log_ok)) begin
      op_ms = cfg.dmt_ms;
    end else begin
      op_ms = fx_ms(t);
    end
    us_fam = cfg.curve inside {[CRV_US_P20:CRV_IEEE_EI]};
    rt = us_fam ? cfg.reset_dial_us : cfg.reset_multiplier_iec;
    if (rt < RT_MIN) rt = RT_MIN;
    if (rt > RT_MAX) rt = RT_MAX;
    forced = cfg.curve inside {CRV_DMT, CRV_RECT, CRV_IEC_LTI, CRV_FR_STI, CRV_UTIL,
                               CRV_LOG_EARTH} || par.tr == '0;
    if (inv_ok && cfg.rst_inv) begin
      if (forced) rst_ms = '0;
      else rst_ms = fx_ms(fx_mul(rt, fx_div(par.tr, FX_ONE - fx_pow(r_raw, par.rp))));
    end else begin
      rst_ms = (cfg.rst_ms > MSW'(RST_MAX_MS)) ? MSW'(RST_MAX_MS) : cfg.rst_ms;
    end
  end

endmodule

// File: bench/itc_meas_model.sv
// partner model: sampling front end that hands rms magnitudes to the core
// assumes the bench sets the target levels; one cycle of conversion latency
`timescale 1ns/1ps
module itc_meas_model
  import itc_pkg::*;
(
  input wire logic core_clk,
  input wire itc_meas_s tgt,
  output itc_meas_s meas
);
  // ==========================================================
  // conversion register
  // all channels move on one edge, so the core never sees a half-updated set
  initial meas = '0;
  always @(posedge core_clk) begin
    meas <= tgt;
  end
endmodule

// File: bench/testbench.sv
// self-checking bench for the timing engine: trip delays, reset hold, thermal
// assumes a shortened tick of 20 cycles; every tick still counts as 10 ms
`timescale 1ns/1ps
module testbench;
  import itc_pkg::*;
  localparam int TK = 20;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  itc_meas_s tgt = '0;
  itc_meas_s meas;
  itc_stage_cfg_s [NSTAGE-1:0] stage_cfg;
  itc_therm_cfg_s therm_cfg;
  logic med_sens = 1'b1;
  logic cut_en = 1'b0;
  logic [NSTAGE-1:0] stage_start;
  logic [NSTAGE-1:0] stage_trip;
  logic [MSW-1:0] thermal_trip_ms;
  itc_fx_t thermal_state;
  logic thermal_trip;
  int err_total = 0;
  int n_checks = 0;
  real th0;

  always #12.5 core_clk = ~core_clk;

  itc_meas_model itc_meas_model_inst (.core_clk(core_clk), .tgt(tgt), .meas(meas));

  itc_timing_core #(.TICK_CYCLES(TK)) itc_timing_core_inst (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .meas(meas),
    .stage_cfg(stage_cfg),
    .therm_cfg(therm_cfg),
    .med_sens(med_sens),
    .cut_en(cut_en),
    .stage_start(stage_start),
    .stage_trip(stage_trip),
    .thermal_trip_ms(thermal_trip_ms),
    .thermal_state(thermal_state),
    .thermal_trip(thermal_trip)
  );

  // ==========================================================
  // reporting
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk_bits(input logic [FW-1:0] got, input logic [FW-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // delays carry 10 ms resolution and an approximate log/exp, hence a band
  task automatic chk_near(input real got, input real exp, input real tol);
    n_checks++;
    if (got < exp - tol || got > exp + tol) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, longint'(got * 1000.0),
               longint'(exp * 1000.0));
    end
  endtask

  // ==========================================================
  // timing helpers
  task automatic ticks(input int n);
    repeat (n * TK) @(posedge core_clk);
    #1;
  endtask

  task automatic wait_trip(input int stg, output int cyc);
    cyc = 0;
    while (stage_trip[stg] !== 1'b1) begin
      @(posedge core_clk);
      #1;
      cyc++;
      if (cyc > 60000) begin
        err_total++;
        $display("mismatch at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        end_sim();
      end
    end
  endtask

  function automatic real inv_ms(input real k, input real c, input real a, input real p,
                                 input real r, input real tms);
    return tms * (k / ($pow(r, a) - p) + c) * 1000.0;
  endfunction

  // ==========================================================
  // one operate delay from a dead start; a trip must leave no elapsed time
  // behind, or the next case (reset hold 600 ms) would trip early
  task automatic op_case(input int stg, input itc_curve_e crv, input real tms,
                         input int cur, input logic cut, input real exp_ms);
    itc_meas_s v;
    int cyc;
    v = '0;
    if (stg < 2) v.phase[stg] = CW'(cur);
    else v.earth = CW'(cur);
    @(posedge core_clk);
    stage_cfg[stg].curve <= crv;
    stage_cfg[stg].tms <= fxr(tms);
    cut_en <= cut;
    // only the stage under test runs; its neighbours share the current
    for (int i = 0; i < NSTAGE; i++) stage_cfg[i].en <= (i == stg);
    tgt <= v;
    wait_trip(stg, cyc);
    chk_near(cyc * 10.0 / TK, exp_ms, exp_ms * 0.05 + 25.0);
    chk_bits(FW'(stage_start[stg]), FW'(1'b1));
    @(posedge core_clk);
    tgt <= '0;
    ticks(2);
    chk_bits(FW'(stage_trip[stg]), FW'(1'b0));
  endtask

  // pulse, dip below 95% for 30 ms, pulse again; measures what was kept
  task automatic hold_case(input int rst, input logic inv, input real exp_ms);
    itc_meas_s v;
    int cyc;
    v = '0;
    v.phase[1] = 16'h07d0;
    @(posedge core_clk);
    stage_cfg[1].curve <= CRV_DMT;
    stage_cfg[1].dmt_ms <= 32'h0000_0064;
    stage_cfg[1].rst_ms <= MSW'(rst);
    stage_cfg[1].rst_inv <= inv;
    for (int i = 0; i < NSTAGE; i++) stage_cfg[i].en <= (i == 1);
    tgt <= v;
    ticks(5);
    v.phase[1] = 16'h0384;
    @(posedge core_clk);
    tgt <= v;
    ticks(3);
    v.phase[1] = 16'h07d0;
    @(posedge core_clk);
    tgt <= v;
    wait_trip(1, cyc);
    chk_near(cyc * 10.0 / TK, exp_ms, 25.0);
    @(posedge core_clk);
    tgt <= '0;
    ticks(2);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    for (int i = 0; i < NSTAGE; i++) begin
      stage_cfg[i] = '0;
      stage_cfg[i].en = 1'b1;
      stage_cfg[i].curve = CRV_DMT;
      stage_cfg[i].pickup_threshold = 16'h03e8;
      stage_cfg[i].tms = fxr(0.1);
      stage_cfg[i].reset_multiplier_iec = FX_ONE;
      stage_cfg[i].reset_dial_us = FX_ONE;
      stage_cfg[i].log_k = FX_ONE;
      stage_cfg[i].dmt_ms = 32'h0000_0032;
      stage_cfg[i].rst_ms = 32'h0000_0258;
    end
    therm_cfg.thermal_current_setting = 16'h00c8;
    therm_cfg.heating_time_constant = fxr(1.0);
    therm_cfg.cooling_time_constant = fxr(100.0);
    therm_cfg.trip_state = fxr(0.5);
    therm_cfg.init_state = fxr(0.3);
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk_bits(thermal_state, '0);
    chk_bits(FW'(stage_trip), '0);
    ticks(1);
    repeat (2) @(posedge core_clk);
    #1;
    chk_bits(thermal_state, therm_cfg.init_state);
    // thermal: one phase under 0.1 setting keeps the heating constant
    @(posedge core_clk);
    tgt.phase[0] <= 16'h000a;
    tgt.phase[1] <= 16'h0064;
    tgt.phase[2] <= 16'h00d2;
    repeat (3) @(posedge core_clk);
    #1;
    chk_near(real'(thermal_trip_ms), 1000.0 * $ln(0.7 / 0.5), 20.0);
    ticks(50);
    th0 = real'(thermal_state) / 65536.0;
    chk_near(th0, 1.0 - 0.7 * $exp(-0.5), 0.03);
    chk_bits(FW'(thermal_trip), FW'(1'b1));
    @(posedge core_clk);
    tgt.phase[0] <= 16'h00d2;
    tgt.phase[1] <= 16'h00d2;
    ticks(50);
    chk_near(real'(thermal_state) / 65536.0,
             th0 + (1.0 - th0) * (1.0 - $exp(-0.005)), 0.02);
    @(posedge core_clk);
    tgt <= '0;
    ticks(2);
    // operate delays at exact power-of-two ratios
    op_case(0, CRV_DMT, 0.1, 2000, 1'b0, 50.0);
    op_case(0, CRV_IEC_VI, 0.1, 2000, 1'b0, inv_ms(13.5, 0, 1, 1, 2, 0.1));
    op_case(0, CRV_IEC_EI, 0.1, 2000, 1'b0, inv_ms(80, 0, 2, 1, 2, 0.1));
    op_case(0, CRV_IEC_LTI, 0.1, 2000, 1'b0, inv_ms(120, 0, 1, 1, 2, 0.1));
    op_case(0, CRV_IEC_SI, 0.1, 2000, 1'b0, inv_ms(0.14, 0, 0.02, 1, 2, 0.1));
    op_case(0, CRV_FR_STI, 0.1, 2000, 1'b0, inv_ms(0.05, 0, 0.04, 1, 2, 0.1));
    op_case(1, CRV_IEEE_VI, 0.1, 2000, 1'b0, inv_ms(19.61, 0.491, 2, 1, 2, 0.1));
    op_case(1, CRV_IEEE_EI, 0.1, 2000, 1'b0, inv_ms(28.2, 0.1217, 2, 1, 2, 0.1));
    op_case(1, CRV_US_LTI, 0.1, 2000, 1'b0, inv_ms(5.95, 0.18, 2, 1, 2, 0.1));
    op_case(0, CRV_RI, 0.1, 2000, 1'b0, inv_ms(-4.2373, 0, -1, 1.43644, 2, 0.1));
    op_case(0, CRV_RI, 0.1, 32000, 1'b0, inv_ms(-4.2373, 0, -1, 1.43644, 20, 0.1));
    op_case(0, CRV_IEC_VI, 1.0, 32000, 1'b0, inv_ms(13.5, 0, 1, 1, 32, 1.0));
    op_case(0, CRV_IEC_VI, 1.0, 32000, 1'b1, inv_ms(13.5, 0, 1, 1, 20, 1.0));
    op_case(0, CRV_LOG_EARTH, 1.0, 2000, 1'b0, 50.0);
    op_case(2, CRV_LOG_EARTH, 1.0, 2000, 1'b0, 1000.0 * (5.8 - 1.35 * $ln(2.0)));
    // reset hold: kept elapsed time, cleared elapsed time, inverse forced to zero
    hold_case(600, 1'b0, 50.0);
    hold_case(0, 1'b0, 100.0);
    hold_case(600, 1'b1, 100.0);
    end_sim();
  end
endmodule
